//--- uar_receiver.sv
// Serial receiver with 9-bit address detect, break handling and APB registers
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "uar_consts.svh"

module uar_receiver (
   input  wire logic        clk_sys,      // System clock, 100 MHz
   input  wire logic        resetn,       // Asynchronous reset, active low
   input  wire logic        psel,         // APB select
   input  wire logic        penable,      // APB access phase
   input  wire logic        pwrite,       // APB direction, high for write
   input  wire logic [7:0]  paddr,        // APB byte address
   input  wire logic [31:0] pwdata,       // APB write data
   output logic      [31:0] prdata,       // APB read data
   output logic             pready,       // APB ready
   output logic             pslverr,      // APB error for unmapped address
   input  wire logic        rxPin,        // Serial receive line from remote node
   output logic             rxIrqReq      // Receive interrupt request level
);

   // ************************************************************************
   // Declarations
   // ************************************************************************
   logic              modEn_r, modEn_nxt;          // Module enable
   logic [1:0]        pds_r, pds_nxt;              // Parity and data select
   logic              stop2_r, stop2_nxt;          // Two stop bits
   logic              txEn_r, txEn_nxt;            // Transmit enable, stored only
   logic [1:0]        iMode_r, iMode_nxt;          // Receive interrupt mode
   logic              addDet_r, addDet_nxt;        // Address detect enable
   logic              irqFlag_r, irqFlag_nxt;      // Receive interrupt flag
   logic              irqEn_r, irqEn_nxt;          // Receive interrupt enable
   logic [2:0]        irqPri_r, irqPri_nxt;        // Receive interrupt priority
   logic [15:0]       baud_r, baud_nxt;            // Baud divisor
   logic [31:0]       rdata_r, rdata_nxt;          // Registered read data
   logic              err_r, err_nxt;              // Registered slave error
   logic              rxMeta_r, rxSync_r;          // Pin synchroniser
   logic [15:0]       divCnt_r, divCnt_nxt;        // Oversample divider
   logic [1:0]        hist_r, hist_nxt;            // Two previous line samples
   uar_pkg::uar_state_t state_r, state_nxt;        // Frame sequencer
   logic [3:0]        sub_r, sub_nxt;              // Sixteenth-of-bit counter
   logic [3:0]        bitCnt_r, bitCnt_nxt;        // Bits taken in this frame
   logic [8:0]        shift_r, shift_nxt;          // Assembled bits
   logic              stopCnt_r, stopCnt_nxt;      // Stop bits taken
   logic              framing_error_flag_r, framing_error_flag_nxt;            // Framing error of frame
   logic [9:0]        fifoMem [0:3];               // Buffer: framing_error_flag, ninth, byte
   logic [1:0]        wrPtr_r, wrPtr_nxt;          // Buffer write pointer
   logic [1:0]        rdPtr_r, rdPtr_nxt;          // Buffer read pointer
   logic [2:0]        cnt_r, cnt_nxt;              // Words held
   logic              tick;                        // Oversample enable pulse
   logic              midTick;                     // Bit-centre enable pulse
   logic              vote;                        // Majority line level
   logic              wordDone;                    // Frame complete, one cycle
   logic [9:0]        doneWord;                    // Completed word
   logic              dropWord;                    // Address filter discard
   logic              push;                        // Word enters buffer
   logic              pop;                         // Word leaves buffer
   logic              setup;                       // APB setup phase
   logic              wrAcc;                       // APB write access edge
   logic              hit;                         // Address is mapped
   logic [2:0]        cntAfter;                    // Count after this cycle

   // ************************************************************************
   // Helper functions
   // ************************************************************************
   // Majority of three samples
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // Data plus parity bits of one frame for a format code
   function automatic logic [3:0] frameBits(input logic [1:0] pds);
      frameBits = (pds == `UAR_PDS_NINE) ? 4'h9 :
                  ((pds == 2'h0) ? 4'h8 : 4'h9);
   endfunction

   // Address decode for the error path; the read mux decodes paddr in its own case
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `UAR_OFS_MODE) || (a == `UAR_OFS_STATUS) ||
               (a == `UAR_OFS_TXHOLD) || (a == `UAR_OFS_RXPORT) ||
               (a == `UAR_OFS_BAUD) || (a == `UAR_OFS_IRQCTL);
   endfunction

   // ************************************************************************
   // Pin synchroniser; only the second stage is read
   // ************************************************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
      end else begin
         rxMeta_r <= rxPin;
         rxSync_r <= rxMeta_r;
      end
   end

   // ************************************************************************
   // APB slave and register file
   // ************************************************************************
   assign setup   = psel & ~penable;
   assign wrAcc   = psel & penable & pwrite;
   assign hit     = mapped(paddr);
   assign pop     = psel & penable & ~pwrite & (paddr == `UAR_OFS_RXPORT) & (cnt_r != 3'h0);
   assign pready  = 1'b1;                       // Zero-wait: data prepared in setup
   assign prdata  = rdata_r;
   assign pslverr = err_r;
   assign rxIrqReq = irqFlag_r & irqEn_r;

   // Next register values, read data captured during the setup phase
   always_comb begin
      modEn_nxt  = modEn_r;
      pds_nxt    = pds_r;
      stop2_nxt  = stop2_r;
      txEn_nxt   = txEn_r;
      iMode_nxt  = iMode_r;
      addDet_nxt = addDet_r;
      irqEn_nxt  = irqEn_r;
      irqPri_nxt = irqPri_r;
      baud_nxt   = baud_r;
      irqFlag_nxt = irqFlag_r;
      rdata_nxt  = rdata_r;
      err_nxt    = 1'b0;
      if (wrAcc && paddr == `UAR_OFS_MODE) begin
         modEn_nxt = pwdata[`UAR_MODE_ENABLE];
         pds_nxt   = pwdata[`UAR_MODE_PDS_HI:`UAR_MODE_PDS_LO];
         stop2_nxt = pwdata[`UAR_MODE_STOP];
         if (!pwdata[`UAR_MODE_ENABLE]) begin
            txEn_nxt = 1'b0;                    // Disabling drops transmit too
         end
      end
      if (wrAcc && paddr == `UAR_OFS_STATUS) begin
         txEn_nxt   = pwdata[`UAR_STA_TXEN] & modEn_r;
         iMode_nxt  = pwdata[`UAR_STA_IMODE_HI:`UAR_STA_IMODE_LO];
         addDet_nxt = pwdata[`UAR_STA_ADDET];
      end
      if (wrAcc && paddr == `UAR_OFS_BAUD) begin
         baud_nxt = pwdata[15:0];
      end
      if (wrAcc && paddr == `UAR_OFS_IRQCTL) begin
         if (pwdata[`UAR_IRQ_FLAG]) begin
            irqFlag_nxt = 1'b0;                 // Write one to clear
         end
         irqEn_nxt  = pwdata[`UAR_IRQ_EN];
         irqPri_nxt = pwdata[`UAR_IRQ_PRI_HI:`UAR_IRQ_PRI_LO];
      end
      // Set wins over a clear in the same cycle
      if (push) begin
         unique case (iMode_r)
            `UAR_IMODE_THREE: if (cntAfter >= `UAR_FIFO_THREE) irqFlag_nxt = 1'b1;
            `UAR_IMODE_FULL:  if (cntAfter == `UAR_FIFO_DEPTH) irqFlag_nxt = 1'b1;
            default:          irqFlag_nxt = 1'b1;
         endcase
      end
      if (setup) begin
         err_nxt   = ~hit;
         rdata_nxt = 32'h0000_0000;
         unique case (paddr)
            `UAR_OFS_MODE:   rdata_nxt = {16'h0000, modEn_r, 12'h000, pds_r, stop2_r};
            `UAR_OFS_STATUS: begin
               rdata_nxt[`UAR_STA_TXEN]  = txEn_r;
               rdata_nxt[`UAR_STA_IMODE_HI:`UAR_STA_IMODE_LO] = iMode_r;
               rdata_nxt[`UAR_STA_ADDET] = addDet_r;
               rdata_nxt[`UAR_STA_IDLE]  = (state_r == uar_pkg::UAR_IDLE);
               rdata_nxt[`UAR_STA_FRAMING_ERROR_FLAG]  = (cnt_r != 3'h0) & fifoMem[rdPtr_r][9];
               rdata_nxt[`UAR_STA_DAV]   = (cnt_r != 3'h0);
            end
            // Byte read in eight-bit formats hides the ninth bit
            `UAR_OFS_RXPORT: if (cnt_r != 3'h0) begin
               rdata_nxt[7:0] = fifoMem[rdPtr_r][7:0];
               rdata_nxt[8]   = (pds_r == `UAR_PDS_NINE) & fifoMem[rdPtr_r][8];
            end
            `UAR_OFS_BAUD:   rdata_nxt = {16'h0000, baud_r};
            `UAR_OFS_IRQCTL: rdata_nxt = {27'h0000000, irqPri_r, irqEn_r, irqFlag_r};
            default:         rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Register file storage
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         modEn_r   <= 1'b0;
         pds_r     <= 2'h0;
         stop2_r   <= 1'b0;
         txEn_r    <= 1'b0;
         iMode_r   <= 2'h0;
         addDet_r  <= 1'b0;
         irqFlag_r <= 1'b0;
         irqEn_r   <= 1'b0;
         irqPri_r  <= 3'h0;
         baud_r    <= `UAR_BAUD_RST;
         rdata_r   <= 32'h0000_0000;
         err_r     <= 1'b0;
      end else begin
         modEn_r   <= modEn_nxt;
         pds_r     <= pds_nxt;
         stop2_r   <= stop2_nxt;
         txEn_r    <= txEn_nxt;
         iMode_r   <= iMode_nxt;
         addDet_r  <= addDet_nxt;
         irqFlag_r <= irqFlag_nxt;
         irqEn_r   <= irqEn_nxt;
         irqPri_r  <= irqPri_nxt;
         baud_r    <= baud_nxt;
         rdata_r   <= rdata_nxt;
         err_r     <= err_nxt;
      end
   end

   // ************************************************************************
   // Frame sequencer at sixteen samples per bit
   // ************************************************************************
   assign tick    = modEn_r & (divCnt_r == baud_r);
   assign midTick = tick & (sub_r == `UAR_OVS_MID);
   assign vote    = maj3(hist_r[1], hist_r[0], rxSync_r);
   assign doneWord = {framing_error_flag_nxt, (pds_r == `UAR_PDS_NINE) & shift_r[8], shift_r[7:0]};

   // Next sequencer values; a break yields a zero byte with the framing error flag set
   always_comb begin
      divCnt_nxt  = tick ? 16'h0000 : (modEn_r ? divCnt_r + 16'h0001 : 16'h0000);
      hist_nxt    = tick ? {hist_r[0], rxSync_r} : hist_r;
      state_nxt   = state_r;
      sub_nxt     = tick ? sub_r + 4'h1 : sub_r;
      bitCnt_nxt  = bitCnt_r;
      shift_nxt   = shift_r;
      stopCnt_nxt = stopCnt_r;
      framing_error_flag_nxt    = framing_error_flag_r;
      wordDone    = 1'b0;
      unique case (state_r)
         uar_pkg::UAR_IDLE: begin
            sub_nxt = 4'h0;
            if (modEn_r && !rxSync_r) begin
               state_nxt  = uar_pkg::UAR_START;
               bitCnt_nxt = 4'h0;
               shift_nxt  = 9'h000;
               framing_error_flag_nxt   = 1'b0;
            end
         end
         uar_pkg::UAR_START: if (midTick) begin
            state_nxt = vote ? uar_pkg::UAR_IDLE : uar_pkg::UAR_DATA; // Glitch reject
         end
         uar_pkg::UAR_DATA: if (midTick) begin
            shift_nxt[bitCnt_r] = vote;       // Parity lands in bit 8, masked later
            bitCnt_nxt = bitCnt_r + 4'h1;
            if (bitCnt_r == frameBits(pds_r) - 4'h1) begin
               state_nxt   = uar_pkg::UAR_STOP;
               stopCnt_nxt = 1'b0;
            end
         end
         uar_pkg::UAR_STOP: if (midTick) begin
            if (!vote) begin
               framing_error_flag_nxt = 1'b1;
            end
            stopCnt_nxt = 1'b1;
            if (stopCnt_r == stop2_r) begin
               wordDone  = 1'b1;
               // A low stop never counts as the next start
               state_nxt = framing_error_flag_nxt ? uar_pkg::UAR_WHIGH : uar_pkg::UAR_IDLE;
            end
         end
         uar_pkg::UAR_WHIGH: if (rxSync_r) begin
            state_nxt = uar_pkg::UAR_IDLE;
         end
         default: state_nxt = uar_pkg::UAR_IDLE;
      endcase
      if (!modEn_r) begin
         state_nxt = uar_pkg::UAR_IDLE;
      end
   end

   // Sequencer registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         divCnt_r  <= 16'h0000;
         hist_r    <= 2'h3;
         state_r   <= uar_pkg::UAR_IDLE;
         sub_r     <= 4'h0;
         bitCnt_r  <= 4'h0;
         shift_r   <= 9'h000;
         stopCnt_r <= 1'b0;
         framing_error_flag_r    <= 1'b0;
      end else begin
         divCnt_r  <= divCnt_nxt;
         hist_r    <= hist_nxt;
         state_r   <= state_nxt;
         sub_r     <= sub_nxt;
         bitCnt_r  <= bitCnt_nxt;
         shift_r   <= shift_nxt;
         stopCnt_r <= stopCnt_nxt;
         framing_error_flag_r    <= framing_error_flag_nxt;
      end
   end

   // ************************************************************************
   // Address filter and four-word receive buffer
   // ************************************************************************
   // Only clean nine-bit data words are filtered; breaks still reach software
   assign dropWord = addDet_r & (pds_r == `UAR_PDS_NINE) & ~doneWord[8] & ~doneWord[9];
   // Address words pass like any other word; a full buffer loses the word unless a read pops one in the same cycle
   assign push     = wordDone & ~dropWord & ((cnt_r != `UAR_FIFO_DEPTH) | pop);
   assign cntAfter = cnt_r + {2'h0, push} - {2'h0, pop};

   // Pointer and count update
   always_comb begin
      wrPtr_nxt = push ? wrPtr_r + 2'h1 : wrPtr_r;
      rdPtr_nxt = pop ? rdPtr_r + 2'h1 : rdPtr_r;
      cnt_nxt   = cntAfter;
   end

   // Buffer storage keeps error and ninth bit beside each byte
   always_ff @(posedge clk_sys) begin
      if (push) begin
         fifoMem[wrPtr_r] <= doneWord;
      end
   end

   // Buffer pointers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wrPtr_r <= 2'h0;
         rdPtr_r <= 2'h0;
         cnt_r   <= 3'h0;
      end else begin
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // ************************************************************************
   // Assertions
   // ************************************************************************
   a_filter_drop: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wordDone && addDet_r && pds_r == `UAR_PDS_NINE && !doneWord[8] && !doneWord[9])
      |-> !push) else $error("filtered word entered buffer");
   a_eight_bit_pass: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wordDone && pds_r != `UAR_PDS_NINE && cnt_r < `UAR_FIFO_DEPTH) |-> push)
      else $error("eight-bit word not buffered");
   a_dav_count: assert property (@(posedge clk_sys) disable iff (!resetn)
      (push && !pop) |=> (cnt_r == $past(cnt_r) + 3'h1) && (cnt_r != 3'h0))
      else $error("buffer count did not rise");
   a_bad_stop_wait: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == uar_pkg::UAR_STOP && wordDone && framing_error_flag_nxt) |=>
      (state_r == uar_pkg::UAR_WHIGH) && !push) else $error("no wait after bad stop");
   a_low_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_r == uar_pkg::UAR_WHIGH && !rxSync_r && modEn_r) |=>
      state_r == uar_pkg::UAR_WHIGH) else $error("left wait with line low");
   a_txen_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wrAcc && paddr == `UAR_OFS_STATUS && !modEn_r) |=> !txEn_r)
      else $error("transmit enabled while module off");
   a_full_irq: assert property (@(posedge clk_sys) disable iff (!resetn)
      (push && !pop && iMode_r == `UAR_IMODE_FULL && cnt_r == 3'h3) |=> irqFlag_r)
      else $error("full-mode interrupt missing");
   a_three_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
      (push && !pop && iMode_r == `UAR_IMODE_THREE && cnt_r == 3'h0 && !irqFlag_r)
      |=> !irqFlag_r) else $error("three-mode fired early");
   a_break_error: assert property (@(posedge clk_sys) disable iff (!resetn)
      (midTick && state_r == uar_pkg::UAR_STOP && !vote && stopCnt_r == stop2_r &&
       cnt_r != `UAR_FIFO_DEPTH) |-> (push && doneWord[9])) else $error("bad stop not buffered");

endmodule

//--- uar_consts.svh
// Register offsets, field positions, reset values and timing counts for the receiver
`ifndef UAR_CONSTS_SVH
`define UAR_CONSTS_SVH

// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define UAR_OFS_MODE      8'h00
`define UAR_OFS_STATUS    8'h04
`define UAR_OFS_TXHOLD    8'h08
`define UAR_OFS_RXPORT    8'h0c
`define UAR_OFS_BAUD      8'h10
`define UAR_OFS_IRQCTL    8'h14

// ****************************************************************************
// Field positions
// ****************************************************************************
`define UAR_MODE_ENABLE   15
`define UAR_MODE_PDS_HI   2
`define UAR_MODE_PDS_LO   1
`define UAR_MODE_STOP     0
`define UAR_STA_TXEN      10
`define UAR_STA_IMODE_HI  7
`define UAR_STA_IMODE_LO  6
`define UAR_STA_ADDET     5
`define UAR_STA_IDLE      4
`define UAR_STA_FRAMING_ERROR_FLAG      2
`define UAR_STA_DAV       0
`define UAR_IRQ_FLAG      0
`define UAR_IRQ_EN        1
`define UAR_IRQ_PRI_HI    4
`define UAR_IRQ_PRI_LO    2

// ****************************************************************************
// Encodings, reset values and timing counts
// ****************************************************************************
`define UAR_PDS_NINE      2'h3
`define UAR_IMODE_THREE   2'h2
`define UAR_IMODE_FULL    2'h3
`define UAR_BAUD_RST      16'h0000
`define UAR_OVS_LAST      4'hf
`define UAR_OVS_MID       4'h8
`define UAR_FIFO_DEPTH    3'h4
`define UAR_FIFO_THREE    3'h3

`endif

//--- uar_pkg.sv
// Types shared by the address-detecting serial receiver
package uar_pkg;

   // Receiver frame sequencer states, one-hot
   typedef enum logic [4:0] {
      UAR_IDLE  = 5'h01,
      UAR_START = 5'h02,
      UAR_DATA  = 5'h04,
      UAR_STOP  = 5'h08,
      UAR_WHIGH = 5'h10
   } uar_state_t;

endpackage

//--- uar_serial_node.sv
// Remote serial node model that drives the receive line
`timescale 1ns/100ps
// ****************************************************************************
// Remote node
// ****************************************************************************
module uar_serial_node #(
   parameter int BITCLK = 16           // Clocks per bit time, divisor 0
) (
   input  wire logic clk_sys,          // System clock, frames are timed on it
   output logic      rxPin             // Receive line, idle high
);
   // Line rests high between frames, the stop level of an idle link
   initial rxPin = 1'b1;

   // Hold one level for whole bit times; a break is just a long low hold
   task automatic lineHold(input logic lvl, input int nBits);
      rxPin <= lvl;
      repeat (nBits * BITCLK) @(posedge clk_sys);
   endtask

   // One frame, LSB first; the ninth bit set marks an address word
   task automatic sendWord(input logic [8:0] w, input int nData, input int nStop);
      lineHold(1'b0, 1);
      for (int i = 0; i < nData; i++) begin
         lineHold(w[i], 1);
      end
      lineHold(1'b1, nStop);
   endtask
endmodule

//--- tb_uart_receiver_address_detect.sv
// Self-checking bench for the address-detecting serial receiver
`timescale 1ns/100ps
`include "uar_consts.svh"
// ****************************************************************************
// Bench top
// ****************************************************************************
module tb_uart_receiver_address_detect;
   logic        clk_sys = 1'b0;        // 100 MHz clock
   logic        resetn  = 1'b0;        // Reset, active low
   logic        psel    = 1'b0;        // APB select
   logic        penable = 1'b0;        // APB access phase
   logic        pwrite  = 1'b0;        // APB direction
   logic [7:0]  paddr   = 8'h00;       // APB address
   logic [31:0] pwdata  = 32'h0;       // APB write data
   logic [31:0] prdata;                // APB read data
   logic        pready;                // APB ready
   logic        pslverr;               // APB error
   logic        rxPin;                 // Line from the remote node
   logic        rxIrqReq;              // Receive interrupt request
   logic [31:0] rdVal;                 // Last read data
   logic        lastErr;               // Last error response
   int          err_total = 0;         // Mismatches
   int          tests_run = 0;         // Comparisons
   int          cyc = 0;               // Timeout counter

   always #5 clk_sys = ~clk_sys;

   uar_receiver uut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxPin(rxPin), .rxIrqReq(rxIrqReq));
   uar_serial_node node (.clk_sys(clk_sys), .rxPin(rxPin));

   // Verdict and end of run, reached from the sequence and the timeout
   task automatic tally_and_finish();
      if (err_total == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Cut a hang short; the whole run needs well under this many cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // One APB transfer; starts at an edge so a release never meets a new setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdVal = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read a register and compare
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdVal, exp);
   endtask

   // ************************************************************************
   // Main sequence
   // ************************************************************************
   initial begin
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      rdChk(`UAR_OFS_STATUS, 32'h10);
      apb(1'b1, `UAR_OFS_STATUS, 32'h400);
      rdChk(`UAR_OFS_STATUS, 32'h10);
      rdChk(8'h18, 32'h0);
      chk({31'h0, lastErr}, 32'h1);
      apb(1'b1, `UAR_OFS_TXHOLD, 32'h1a5);
      rdChk(`UAR_OFS_TXHOLD, 32'h0);
      chk({31'h0, lastErr}, 32'h0);
      apb(1'b1, `UAR_OFS_BAUD, 32'h0);
      apb(1'b1, `UAR_OFS_MODE, 32'h8000);
      apb(1'b1, `UAR_OFS_STATUS, 32'h20);
      node.sendWord(9'h0a5, 8, 1);
      rdChk(`UAR_OFS_STATUS, 32'h31);
      rdChk(`UAR_OFS_RXPORT, 32'ha5);
      // Nine-bit, two stop bits: data word dropped, address word kept
      apb(1'b1, `UAR_OFS_MODE, 32'h8007);
      node.sendWord(9'h055, 9, 2);
      node.sendWord(9'h1a3, 9, 2);
      rdChk(`UAR_OFS_RXPORT, 32'h1a3);
      rdChk(`UAR_OFS_STATUS, 32'h30);
      // Address matched: filter off, data buffered; then filter back on
      apb(1'b1, `UAR_OFS_STATUS, 32'h80);
      node.sendWord(9'h055, 9, 2);
      rdChk(`UAR_OFS_RXPORT, 32'h55);
      apb(1'b1, `UAR_OFS_STATUS, 32'h20);
      node.sendWord(9'h066, 9, 2);
      rdChk(`UAR_OFS_STATUS, 32'h30);
      // Every interrupt mode, four words each, then drain
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `UAR_OFS_STATUS, 32'(m) << 6);
         apb(1'b1, `UAR_OFS_IRQCTL, 32'h3);
         for (int k = 0; k < 4; k++) begin
            node.sendWord(9'(k), 9, 2);
            chk({31'h0, rxIrqReq}, {31'h0, k >= (m < 2 ? 0 : m)});
         end
         for (int k = 0; k < 4; k++) begin
            rdChk(`UAR_OFS_RXPORT, 32'(k));
         end
      end
      // Parity formats: a wrong frame length would flag a framing error
      apb(1'b1, `UAR_OFS_MODE, 32'h8002);
      node.sendWord(9'h05a, 9, 1);
      rdChk(`UAR_OFS_STATUS, 32'hd1);
      rdChk(`UAR_OFS_RXPORT, 32'h5a);
      apb(1'b1, `UAR_OFS_MODE, 32'h8005);
      rdChk(`UAR_OFS_MODE, 32'h8005);
      node.sendWord(9'h1c3, 9, 2);
      rdChk(`UAR_OFS_RXPORT, 32'hc3);
      // Break: zero word with framing error, no idle until the line is high
      apb(1'b1, `UAR_OFS_MODE, 32'h8000);
      apb(1'b1, `UAR_OFS_STATUS, 32'h0);
      node.lineHold(1'b0, 12);
      rdChk(`UAR_OFS_STATUS, 32'h05);
      node.lineHold(1'b0, 2);
      node.lineHold(1'b1, 2);
      rdChk(`UAR_OFS_STATUS, 32'h15);
      rdChk(`UAR_OFS_RXPORT, 32'h0);
      rdChk(`UAR_OFS_STATUS, 32'h10);
      // Priority stored, flag cleared, request masked when disabled
      apb(1'b1, `UAR_OFS_IRQCTL, 32'h15);
      rdChk(`UAR_OFS_IRQCTL, 32'h14);
      chk({31'h0, rxIrqReq}, 32'h0);
      // Mid-run reset returns mode, interrupt control and status to their reset values
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rdChk(`UAR_OFS_MODE, 32'h0);
      rdChk(`UAR_OFS_IRQCTL, 32'h0);
      rdChk(`UAR_OFS_STATUS, 32'h10);
      apb(1'b1, `UAR_OFS_BAUD, 32'h0001_2345);
      rdChk(`UAR_OFS_BAUD, 32'h2345);
      tally_and_finish();
   end
endmodule
